/* File: verilog/hbfm_pkg.sv */
// package: constants and types for the half-bridge fault manager
// Behaviour
// - stopped active-freewheel upper: lower switch instead
// - light-load select lowers open-load threshold, filter
// - nonzero frequency write restarts PWM period
// - any overcurrent or open-load latches load error
// - hard faults tristate outputs, enables kept
// - open-load latches flags, output unchanged
// - temperature warning latches bit one only
// - temperature shutdown latches all outputs off
// - undervoltage latches flag, outputs auto-recover
// - overvoltage latches flag, outputs auto-recover
// - overcurrent starts per-switch filter timer
// - filter expiry latches switch off, sets bit
// - switch stays off while overcurrent bit set
// - upper monitors short to ground, lower to supply
package hbfm_pkg;
   localparam int HBFM_NHB = 6;
   localparam int HBFM_CLK_MHZ = 100;
   localparam int HBFM_OC_FILT_NS = 10000;
   localparam int HBFM_OL_FILT_NS = 200000;
   localparam int HBFM_OL_LED_FILT_NS = 50000;
   localparam int HBFM_OC_FILT_CYC = HBFM_OC_FILT_NS * HBFM_CLK_MHZ / 1000;
   localparam int HBFM_OL_FILT_CYC = HBFM_OL_FILT_NS * HBFM_CLK_MHZ / 1000;
   localparam int HBFM_OL_LED_CYC = HBFM_OL_LED_FILT_NS * HBFM_CLK_MHZ / 1000;
   localparam int HBFM_CNT_W = 16;
   localparam int HBFM_GS_LE = 6;
   localparam int HBFM_GS_UV = 5;
   localparam int HBFM_GS_OV = 4;
   localparam int HBFM_GS_TSD = 2;
   localparam int HBFM_GS_TPW = 1;
   localparam logic [7:0] HBFM_GS_RST = 8'h00;
   localparam logic [1:0] HBFM_FREQ_STOP = 2'h0;
   // current sense comparator results per half-bridge
   typedef struct packed {
      logic [HBFM_NHB-1:0] up_oc;
      logic [HBFM_NHB-1:0] lo_oc;
      logic [HBFM_NHB-1:0] up_ol;
      logic [HBFM_NHB-1:0] up_ol_led;
      logic [HBFM_NHB-1:0] lo_ol;
   } hbfm_sense_s;
endpackage

/* File: verilog/hbfm_top.sv */
// module: fault latching and output gating for six half-bridges
`timescale 1ns/100ps
module hbfm_top
   import hbfm_pkg::*;
#(
   parameter int NHB = HBFM_NHB,
   parameter int OC_CYC = HBFM_OC_FILT_CYC,
   parameter int OL_CYC = HBFM_OL_FILT_CYC,
   parameter int OL_LED_CYC = HBFM_OL_LED_CYC
) (
   input wire logic i_ref_clk, // 100 MHz
   input wire logic i_rstn, // sync reset, low active
   input wire logic [NHB-1:0] i_up_en, // upper switch enables
   input wire logic [NHB-1:0] i_lo_en, // lower switch enables
   input wire logic [NHB-1:0] i_pwm_assigned, // channel assigned
   input wire logic [NHB-1:0] i_active_fw, // active freewheel sel
   input wire logic [NHB-1:0] i_freq_stopped, // channel freq = 00
   input wire logic [NHB-1:0] i_pwm_level, // pwm on-phase
   input wire logic [2:0] i_freq_wr, // freq write strobe per ch
   input wire logic [5:0] i_freq_val, // 2 bits per channel
   input wire logic i_light_load_select_upper_1, // led mode hb1
   input wire logic i_light_load_select_upper_2, // led mode hb2
   input wire hbfm_sense_s i_sense, // comparator outputs
   input wire logic i_temp_warn, // warning level reached
   input wire logic i_temp_sd, // shutdown level reached
   input wire logic i_supply_uv, // supply undervoltage
   input wire logic i_supply_ov, // supply overvoltage
   input wire logic [7:0] i_gs_clr, // clear bits, global status
   input wire logic [NHB-1:0] i_up_oc_clr, // clear upper oc bits
   input wire logic [NHB-1:0] i_lo_oc_clr, // clear lower oc bits
   input wire logic [NHB-1:0] i_up_ol_clr, // clear upper ol bits
   input wire logic [NHB-1:0] i_lo_ol_clr, // clear lower ol bits
   output logic [NHB-1:0] o_up_drv, // upper gate drive
   output logic [NHB-1:0] o_lo_drv, // lower gate drive
   output logic [2:0] o_period_restart, // pwm period restart pulse
   output logic [NHB-1:0] o_ol_led_thr, // low ol threshold sel
   output logic [7:0] o_global_status_one, // global status
   output logic [NHB-1:0] o_upper_overcurrent_bit, // upper oc latched
   output logic [NHB-1:0] o_lower_overcurrent_bit, // lower oc latched
   output logic [NHB-1:0] o_upper_openload_bit, // upper ol latched
   output logic [NHB-1:0] o_lower_openload_bit // lower ol latched
);
   logic [NHB-1:0] up_oc_ff, lo_oc_ff, up_ol_ff, lo_ol_ff;
   logic [NHB-1:0] nxt_up_oc, nxt_lo_oc, nxt_up_ol, nxt_lo_ol;
   logic [7:0] gs_ff;
   logic [7:0] nxt_gs;
   logic [HBFM_CNT_W-1:0] oc_up_cnt_ff [NHB];
   logic [HBFM_CNT_W-1:0] oc_lo_cnt_ff [NHB];
   logic [HBFM_CNT_W-1:0] ol_up_cnt_ff [NHB];
   logic [HBFM_CNT_W-1:0] ol_lo_cnt_ff [NHB];
   logic [NHB-1:0] led_sel;
   logic [NHB-1:0] up_on, lo_on, up_oc_exp, lo_oc_exp;
   logic [NHB-1:0] up_ol_exp, lo_ol_exp;
   logic [NHB-1:0] up_req, lo_req, fw_swap;
   wire all_off = gs_ff[HBFM_GS_TSD] | i_supply_uv | i_supply_ov
      | i_temp_sd;

   assign led_sel = {{(NHB-2){1'b0}}, i_light_load_select_upper_2,
      i_light_load_select_upper_1};
   // stopped channel with active freewheel hands over to lower
   assign fw_swap = i_up_en & i_pwm_assigned & i_active_fw
      & i_freq_stopped;
   assign up_req = i_up_en & ~fw_swap & (~i_pwm_assigned | i_pwm_level);
   assign lo_req = i_lo_en | fw_swap;
   // enables are only read, so the host view never changes
   assign up_on = up_req & ~up_oc_ff & {NHB{~all_off}};
   assign lo_on = lo_req & ~lo_oc_ff & {NHB{~all_off}};

   genvar g;
   generate
      for (g = 0; g < NHB; g++) begin : g_hb
         // upper senses short to ground, lower short to supply
         assign up_oc_exp[g] = oc_up_cnt_ff[g] >= HBFM_CNT_W'(OC_CYC - 1)
            && i_sense.up_oc[g] && up_on[g];
         assign lo_oc_exp[g] = oc_lo_cnt_ff[g] >= HBFM_CNT_W'(OC_CYC - 1)
            && i_sense.lo_oc[g] && lo_on[g];
         assign up_ol_exp[g] = ol_up_cnt_ff[g] >= (led_sel[g] ?
            HBFM_CNT_W'(OL_LED_CYC - 1) : HBFM_CNT_W'(OL_CYC - 1))
            && (led_sel[g] ? i_sense.up_ol_led[g] : i_sense.up_ol[g])
            && up_on[g];
         assign lo_ol_exp[g] = ol_lo_cnt_ff[g] >= HBFM_CNT_W'(OL_CYC - 1)
            && i_sense.lo_ol[g] && lo_on[g];
         always_ff @(posedge i_ref_clk) begin
            if (!i_rstn) begin
               oc_up_cnt_ff[g] <= '0;
               oc_lo_cnt_ff[g] <= '0;
               ol_up_cnt_ff[g] <= '0;
               ol_lo_cnt_ff[g] <= '0;
            end else begin
               // filter timers, restart whenever condition drops
               oc_up_cnt_ff[g] <= (i_sense.up_oc[g] && up_on[g] &&
                  !up_oc_exp[g]) ? oc_up_cnt_ff[g] + 1'b1 : '0;
               oc_lo_cnt_ff[g] <= (i_sense.lo_oc[g] && lo_on[g] &&
                  !lo_oc_exp[g]) ? oc_lo_cnt_ff[g] + 1'b1 : '0;
               ol_up_cnt_ff[g] <= ((led_sel[g] ? i_sense.up_ol_led[g] :
                  i_sense.up_ol[g]) && up_on[g] && !up_ol_exp[g]) ?
                  ol_up_cnt_ff[g] + 1'b1 : '0;
               ol_lo_cnt_ff[g] <= (i_sense.lo_ol[g] && lo_on[g] &&
                  !lo_ol_exp[g]) ? ol_lo_cnt_ff[g] + 1'b1 : '0;
            end
         end
      end
   endgenerate

   // set beats clear so a fault still present re-latches
   assign nxt_up_oc = (up_oc_ff & ~i_up_oc_clr) | up_oc_exp;
   assign nxt_lo_oc = (lo_oc_ff & ~i_lo_oc_clr) | lo_oc_exp;
   assign nxt_up_ol = (up_ol_ff & ~i_up_ol_clr) | up_ol_exp;
   assign nxt_lo_ol = (lo_ol_ff & ~i_lo_ol_clr) | lo_ol_exp;

   always_comb begin
      nxt_gs = gs_ff & ~i_gs_clr;
      nxt_gs[HBFM_GS_LE] = nxt_gs[HBFM_GS_LE] | (|up_oc_exp)
         | (|lo_oc_exp) | (|up_ol_exp) | (|lo_ol_exp);
      nxt_gs[HBFM_GS_TPW] = nxt_gs[HBFM_GS_TPW] | i_temp_warn;
      nxt_gs[HBFM_GS_TSD] = nxt_gs[HBFM_GS_TSD] | i_temp_sd;
      nxt_gs[HBFM_GS_UV] = nxt_gs[HBFM_GS_UV] | i_supply_uv;
      nxt_gs[HBFM_GS_OV] = nxt_gs[HBFM_GS_OV] | i_supply_ov;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         up_oc_ff <= '0;
         lo_oc_ff <= '0;
         up_ol_ff <= '0;
         lo_ol_ff <= '0;
         gs_ff <= HBFM_GS_RST;
         o_up_drv <= '0;
         o_lo_drv <= '0;
         o_period_restart <= '0;
         o_ol_led_thr <= '0;
      end else begin
         up_oc_ff <= nxt_up_oc;
         lo_oc_ff <= nxt_lo_oc;
         up_ol_ff <= nxt_up_ol;
         lo_ol_ff <= nxt_lo_ol;
         gs_ff <= nxt_gs;
         o_up_drv <= up_on & ~up_oc_exp;
         o_lo_drv <= lo_on & ~lo_oc_exp;
         o_ol_led_thr <= led_sel;
         for (int c = 0; c < 3; c++) begin
            o_period_restart[c] <= i_freq_wr[c] &&
               i_freq_val[2*c +: 2] != HBFM_FREQ_STOP;
         end
      end
   end

   assign o_global_status_one = gs_ff;
   assign o_upper_overcurrent_bit = up_oc_ff;
   assign o_lower_overcurrent_bit = lo_oc_ff;
   assign o_upper_openload_bit = up_ol_ff;
   assign o_lower_openload_bit = lo_ol_ff;

   // checks aim at bridge 1 and bridge 6, where the bench puts its faults
   sequence s_hb1_free;
      up_req[0] && !all_off && !up_oc_ff[0] && !up_oc_exp[0];
   endsequence

   a_le_follows: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      (|up_oc_exp || |lo_oc_exp || |up_ol_exp || |lo_ol_exp)
      |=> gs_ff[HBFM_GS_LE]) else $error("load error not latched");

   a_oc_keeps_off: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn) up_oc_ff[0] |=> !o_up_drv[0])
      else $error("upper switch on while oc set");

   a_lo_oc_off: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn) lo_oc_ff[NHB-1] |=> !o_lo_drv[NHB-1])
      else $error("lower switch on while oc set");

   a_oc_bit_set: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn) up_oc_exp[0] |=> up_oc_ff[0] && !o_up_drv[0])
      else $error("upper oc not latched");

   a_lo_oc_set: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      lo_oc_exp[NHB-1] |=> lo_oc_ff[NHB-1] && !o_lo_drv[NHB-1])
      else $error("lower oc not latched");

   a_tsd_all_off: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      gs_ff[HBFM_GS_TSD] |=> (o_up_drv == '0 && o_lo_drv == '0))
      else $error("outputs on during shutdown latch");

   a_tsd_latch: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn) i_temp_sd |=> gs_ff[HBFM_GS_TSD])
      else $error("shutdown flag not latched");

   a_uv_off: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      i_supply_uv |=> (o_up_drv == '0 && o_lo_drv == '0
      && gs_ff[HBFM_GS_UV])) else $error("undervoltage not handled");

   // recovery needs no host action once the supply is back
   a_auto_resume: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn) s_hb1_free |=> o_up_drv[0])
      else $error("upper switch did not resume");

   a_ov_off: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      i_supply_ov |=> (o_up_drv == '0 && o_lo_drv == '0
      && gs_ff[HBFM_GS_OV])) else $error("overvoltage not handled");

   a_fw_swap: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      (fw_swap[0] && !all_off && !lo_oc_ff[0] && !lo_oc_exp[0])
      |=> (o_lo_drv[0] && !o_up_drv[0])) else $error("freewheel swap");

   a_restart: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      (i_freq_wr[0] && i_freq_val[1:0] != HBFM_FREQ_STOP)
      |=> o_period_restart[0]) else $error("period not restarted");

   a_led_thr: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      i_light_load_select_upper_1 |=> o_ol_led_thr[0])
      else $error("light load threshold not selected");

   a_ol_no_off: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      up_ol_exp[0] && !up_oc_exp[0] |=> o_up_drv[0] && up_ol_ff[0])
      else $error("open load changed output");

   a_lo_ol_keep: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      lo_ol_exp[NHB-1] && !lo_oc_exp[NHB-1]
      |=> o_lo_drv[NHB-1] && lo_ol_ff[NHB-1])
      else $error("lower open load changed output");

   a_tpw_latch: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn) i_temp_warn |=> gs_ff[HBFM_GS_TPW])
      else $error("warning not latched");
endmodule

/* File: tb/hbfm_host.sv */
// host model: status clear pulses as a register write would give
`timescale 1ns/100ps
module hbfm_host (
   input wire logic i_ref_clk, // clock
   input wire logic i_clr_req, // level request from bench
   output logic [7:0] o_gs_clr, // global status clear
   output logic [5:0] o_sw_clr // per-switch clear
);
   logic req_ff;
   logic pulse;
   always_ff @(posedge i_ref_clk) begin
      req_ff <= i_clr_req;
   end
   // one pulse per request edge; a held level would mask re-latching
   assign pulse = i_clr_req & ~req_ff;
   assign o_gs_clr = {8{pulse}};
   assign o_sw_clr = {6{pulse}};
endmodule

/* File: tb/tb.sv */
// bench: fault latching, output gating and recovery checks
`timescale 1ns/100ps
module tb;
   import hbfm_pkg::*;
   typedef struct packed {
      logic [3:0] cond;
      logic [7:0] drv;
      logic [7:0] drv_rec;
      logic [7:0] gs;
   } hbfm_row_s;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic clr = 1'b0;
   logic led1 = 1'b0;
   logic led2 = 1'b0;
   logic [3:0] cnd = 4'h0;
   logic [5:0] up_en = 6'h1F, lo_en = 6'h20, asg = 6'h00, afw = 6'h00;
   logic [5:0] fstop = 6'h00, pwml = 6'h00, fval = 6'h00;
   logic [2:0] fwr = 3'h0;
   hbfm_sense_s sense = '0;
   logic [7:0] gs_clr, gs;
   logic [5:0] sw_clr, o_up, o_lo, led_thr, uoc, loc, uol, lol;
   logic [2:0] rst_p;
   int n_errors = 0;
   int samples_checked = 0;
   hbfm_row_s rows [4] = '{
      '{4'h1, 8'h1F, 8'h1F, 8'h02},
      '{4'h2, 8'h00, 8'h00, 8'h04},
      '{4'h4, 8'h00, 8'h1F, 8'h20},
      '{4'h8, 8'h00, 8'h1F, 8'h10}};
   always #5 clk = ~clk;
   hbfm_host u_hbfm_host (.i_ref_clk(clk), .i_clr_req(clr),
      .o_gs_clr(gs_clr), .o_sw_clr(sw_clr));
   hbfm_top #(.OC_CYC(4), .OL_CYC(8), .OL_LED_CYC(4)) u_hbfm_top (
      .i_ref_clk(clk), .i_rstn(rstn), .i_up_en(up_en), .i_lo_en(lo_en),
      .i_pwm_assigned(asg), .i_active_fw(afw), .i_freq_stopped(fstop),
      .i_pwm_level(pwml), .i_freq_wr(fwr), .i_freq_val(fval),
      .i_light_load_select_upper_1(led1),
      .i_light_load_select_upper_2(led2), .i_sense(sense),
      .i_temp_warn(cnd[0]), .i_temp_sd(cnd[1]), .i_supply_uv(cnd[2]),
      .i_supply_ov(cnd[3]), .i_gs_clr(gs_clr), .i_up_oc_clr(sw_clr),
      .i_lo_oc_clr(sw_clr), .i_up_ol_clr(sw_clr), .i_lo_ol_clr(sw_clr),
      .o_up_drv(o_up), .o_lo_drv(o_lo), .o_period_restart(rst_p),
      .o_ol_led_thr(led_thr), .o_global_status_one(gs),
      .o_upper_overcurrent_bit(uoc), .o_lower_overcurrent_bit(loc),
      .o_upper_openload_bit(uol), .o_lower_openload_bit(lol));
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic clear();
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #50000;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge clk);
      #1;
      chk("reset drive", 8'h00, {2'h0, o_up});
      chk("reset status", 8'h00, gs);
      @(posedge clk) rstn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) cnd <= rows[i].cond;
         repeat (3) @(posedge clk);
         #1;
         chk("drive", rows[i].drv, {2'h0, o_up});
         chk("status", rows[i].gs, gs);
         @(posedge clk) cnd <= 4'h0;
         repeat (3) @(posedge clk);
         #1;
         chk("recover", rows[i].drv_rec, {2'h0, o_up});
         clear();
         chk("cleared", 8'h00, gs);
         chk("resumed", 8'h1F, {2'h0, o_up});
         $display("row %0d done", i);
      end
      // short to ground on upper 1, short to supply on lower 6
      @(posedge clk) sense <= '{up_oc: 6'h01, lo_oc: 6'h20, default: '0};
      repeat (10) @(posedge clk);
      #1;
      chk("oc up drive", 8'h1E, {2'h0, o_up});
      chk("oc lo drive", 8'h00, {2'h0, o_lo});
      chk("oc up bit", 8'h01, {2'h0, uoc});
      chk("oc lo bit", 8'h20, {2'h0, loc});
      chk("oc load err", 8'h40, gs);
      clear();
      repeat (10) @(posedge clk);
      #1;
      chk("oc relatch", 8'h01, {2'h0, uoc});
      chk("oc held off", 8'h1E, {2'h0, o_up});
      @(posedge clk) sense <= '{up_ol: 6'h05, lo_ol: 6'h20, default: '0};
      clear();
      chk("oc release", 8'h1F, {2'h0, o_up});
      repeat (14) @(posedge clk);
      #1;
      chk("ol bit", 8'h05, {2'h0, uol});
      chk("ol drive", 8'h1F, {2'h0, o_up});
      chk("lo ol bit", 8'h20, {2'h0, lol});
      chk("lo ol drive", 8'h20, {2'h0, o_lo});
      chk("ol load err", 8'h40, gs);
      $display("overcurrent and open load done");
      @(posedge clk) sense <= '0;
      led1 <= 1'b1;
      asg <= 6'h01;
      afw <= 6'h01;
      fstop <= 6'h01;
      repeat (3) @(posedge clk);
      #1;
      chk("led thr", 8'h01, {2'h0, led_thr});
      chk("fw up", 8'h1E, {2'h0, o_up});
      chk("fw lo", 8'h21, {2'h0, o_lo});
      // a zero write must not restart: the channel stays stopped
      @(posedge clk) fwr <= 3'h1;
      @(posedge clk) fwr <= 3'h0;
      #1;
      chk("no restart", 8'h00, {5'h0, rst_p});
      @(posedge clk) fwr <= 3'h1;
      fval <= 6'h02;
      @(posedge clk) fwr <= 3'h0;
      #1;
      chk("restart", 8'h01, {5'h0, rst_p});
      $display("light load and pwm done");
      finish_test();
   end
endmodule
